// ==== verilog/drt_consts.svh ====
// Purpose: named constants of the dma request and termination block
// Assumes: included by the package and by the core
// Notes:   offsets are byte addresses on the register port
`ifndef DRT_CONSTS_SVH
`define DRT_CONSTS_SVH

// register offsets
`define DRT_OFF_MODE   8'h00
`define DRT_OFF_STATUS 8'h04
`define DRT_OFF_COUNT  8'h08
`define DRT_OFF_SRC    8'h0C
`define DRT_OFF_DST    8'h10
`define DRT_OFF_FC     8'h14

// request source selections
`define DRT_REQ_MAX    2'h0
`define DRT_REQ_LIM    2'h1
`define DRT_REQ_BURST  2'h2
`define DRT_REQ_STEAL  2'h3

// bandwidth share selections
`define DRT_BW_EIGHTH  2'h0
`define DRT_BW_QUARTER 2'h1
`define DRT_BW_HALF    2'h2
`define DRT_BW_3QUART  2'h3

// limited-rate window length in clocks, and its counter wrap value
`define DRT_WINDOW     11'h400
`define DRT_WIN_LAST   10'h3FF

// operand sizes in bytes and reset values
`define DRT_OP_BYTE    16'h0001
`define DRT_OP_WORD    16'h0002
`define DRT_PTR_STEP   24'h000001
`define DRT_MODE_RST   15'h0000
`define DRT_STAT_RST   4'h0
`define DRT_CNT_RST    16'h0000
`define DRT_PTR_RST    24'h000000
`define DRT_FC_RST     8'h00

`endif

// ==== verilog/drt_pkg.sv ====
// Purpose: types of the dma request and termination block
// Assumes: constants come from drt_consts.svh
// Notes:   packed struct field order fixes the register bit layout
`include "drt_consts.svh"
package drt_pkg;

  // channel sequencer states
  typedef enum logic [2:0] {
    DRT_IDLE = 3'h0,
    DRT_ARB  = 3'h1,
    DRT_RD   = 3'h2,
    DRT_WR   = 3'h3,
    DRT_HOLD = 3'h4
  } drt_fsm_t;

  // channel mode register, bit 0 is the go bit
  typedef struct packed {
    logic       dst_inc;
    logic       src_inc;
    logic       periph_pack;
    logic       periph_is_dest;
    logic       mem2mem;
    logic       word_op;
    logic       error_irq_enable;
    logic       normal_irq_enable;
    logic       end_on_side_sel;
    logic       bus_clear_mask;
    logic [1:0] bandwidth_limit_sel;
    logic [1:0] request_source_sel;
    logic       channel_go_bit;
  } drt_mode_t;

  // channel status register, write one to clear
  typedef struct packed {
    logic src_bus_fault_flag;
    logic dest_bus_fault_flag;
    logic external_end_flag;
    logic complete_flag;
  } drt_stat_t;

  // one bus cycle request to the system bus sequencer
  typedef struct packed {
    logic        write;
    logic [2:0]  fc;
    logic [23:0] addr;
  } drt_cyc_t;

  // whole state of the core
  typedef struct packed {
    drt_fsm_t    fsm;
    drt_mode_t   mode;
    drt_stat_t   stat;
    logic [15:0] bc;
    logic [23:0] src;
    logic [23:0] dst;
    logic [7:0]  fc;
    logic [9:0]  win;
    logic [10:0] used;
    logic        periph_request_in_m;
    logic        periph_request_in_s;
    logic        periph_request_in_p;
    logic        end_m;
    logic        end_s;
    logic        steal_pend;
    logic        await_ack;
    logic        burst_smp;
    logic        last_op;
    logic        ext_hit;
    logic        cidx;
    drt_cyc_t    cyc;
    logic        irq_n;
    logic        irq_e;
    logic [31:0] rdata;
  } drt_state_t;

endpackage

// ==== verilog/drt_core.sv ====
// Purpose: request generation, termination and programming of one dma channel
// Assumes: one 250 MHz clock, synchronous active-low reset, bus cycles run by an outside sequencer
// Notes:   request and block-end pins pass two flops before use
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "drt_consts.svh"
module drt_core (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // system bus ownership and cycles
  output logic                   bus_req,
  input  wire logic              bus_grant,
  input  wire logic              ext_master_req,
  input  wire logic              core_irq_pend,
  output logic                   cyc_req,
  output drt_pkg::drt_cyc_t      cyc_out,
  input  wire logic              cyc_done,
  input  wire logic              cyc_err,
  // peripheral pins
  input  wire logic              periph_request_in,
  output logic                   periph_ack_out,
  input  wire logic              blk_end_in,
  output logic                   blk_end_out,
  output logic                   blk_end_oe,
  // pending-bit events to the interrupt controller
  output logic                   irq_normal,
  output logic                   irq_error
);

  drt_pkg::drt_state_t q;
  drt_pkg::drt_state_t s;

  logic        owned;
  logic        periph_side;
  logic        final_cyc;
  logic [15:0] op_bytes;
  logic [10:0] allot;
  logic        clear_now;
  logic        pend_idle;
  logic        pend_hold;
  logic        steal_edge;
  logic        end_drive;
  logic [15:0] bc_next;

  // decode of the current cycle, all from flops except the bus clear inputs ext_master_req and core_irq_pend
  always_comb begin
    owned       = (q.fsm == drt_pkg::DRT_RD) || (q.fsm == drt_pkg::DRT_WR);
    periph_side = !q.mode.mem2mem &&
                  ((q.fsm == drt_pkg::DRT_RD) ? !q.mode.periph_is_dest : q.mode.periph_is_dest);
    final_cyc   = !(periph_side && q.mode.periph_pack) || q.cidx;
    op_bytes    = q.mode.word_op ? `DRT_OP_WORD : `DRT_OP_BYTE;
    bc_next     = q.bc - op_bytes;
    clear_now   = ext_master_req || (core_irq_pend && q.mode.bus_clear_mask);
    steal_edge  = q.periph_request_in_s && !q.periph_request_in_p;
    unique case (q.mode.bandwidth_limit_sel)
      `DRT_BW_EIGHTH:  allot = `DRT_WINDOW >> 3;
      `DRT_BW_QUARTER: allot = `DRT_WINDOW >> 2;
      `DRT_BW_HALF:    allot = `DRT_WINDOW >> 1;
      `DRT_BW_3QUART:  allot = (`DRT_WINDOW >> 1) + (`DRT_WINDOW >> 2);
    endcase
  end

  // request pending; burst continuation uses the sample from the last peripheral cycle
  always_comb begin
    pend_idle = 1'b0;
    pend_hold = 1'b0;
    unique case (q.mode.request_source_sel)
      `DRT_REQ_MAX: begin
        pend_idle = 1'b1;
        pend_hold = 1'b1;
      end
      `DRT_REQ_LIM: begin
        pend_idle = q.used < allot;
        pend_hold = q.used < allot;
      end
      `DRT_REQ_BURST: begin
        pend_idle = q.periph_request_in_s;
        pend_hold = q.burst_smp;
      end
      `DRT_REQ_STEAL: begin
        pend_idle = q.steal_pend;
        pend_hold = q.steal_pend;
      end
    endcase
    pend_idle = pend_idle && q.mode.channel_go_bit;
    pend_hold = pend_hold && q.mode.channel_go_bit;
  end

  // next state
  always_comb begin
    s       = q;
    s.irq_n = 1'b0;
    s.irq_e = 1'b0;
    s.rdata = 32'h0000_0000;
    // pins pass two flops before anything reads them
    s.periph_request_in_m = periph_request_in;
    s.periph_request_in_s = q.periph_request_in_m;
    s.periph_request_in_p = q.periph_request_in_s;
    s.end_m  = blk_end_in;
    s.end_s  = q.end_m;
    // bandwidth window: usage restarts at every window edge
    s.win = q.win + 10'h001;
    if (q.win == `DRT_WIN_LAST) begin
      s.used = 11'h000;
    end else if (owned && (q.used != `DRT_WINDOW)) begin
      s.used = q.used + 11'h001;
    end
    // cycle-steal edge, only while go is set and no acknowledge is awaited
    if (q.mode.channel_go_bit && steal_edge && !q.await_ack) begin
      s.steal_pend = 1'b1;
    end
    if (periph_ack_out) begin
      s.await_ack = 1'b0;
    end
    // register writes; status clear first so a hardware set below wins
    if (reg_wr) begin
      unique case (reg_addr)
        `DRT_OFF_MODE:   s.mode = reg_wdata[14:0];
        `DRT_OFF_STATUS: s.stat = q.stat & ~reg_wdata[3:0];
        `DRT_OFF_COUNT:  if (!q.mode.channel_go_bit) s.bc = reg_wdata[15:0];
        `DRT_OFF_SRC:    if (!q.mode.channel_go_bit) s.src = reg_wdata[23:0];
        `DRT_OFF_DST:    if (!q.mode.channel_go_bit) s.dst = reg_wdata[23:0];
        `DRT_OFF_FC:     if (!q.mode.channel_go_bit) s.fc = reg_wdata[7:0];
        default:         ;
      endcase
    end
    // sequencer
    unique case (q.fsm)
      drt_pkg::DRT_IDLE: begin
        if (pend_idle && !clear_now) begin
          s.fsm = drt_pkg::DRT_ARB;
        end
      end
      drt_pkg::DRT_ARB: begin
        if (!pend_idle) begin
          s.fsm = drt_pkg::DRT_IDLE;
        end else if (bus_grant) begin
          s.fsm        = drt_pkg::DRT_RD;
          s.cidx       = 1'b0;
          s.last_op    = (q.bc == op_bytes);
          s.ext_hit    = 1'b0;
          s.steal_pend = 1'b0;
          s.await_ack  = !q.mode.mem2mem;                                  // memory-only operands never acknowledge
          s.cyc        = '{write: 1'b0, fc: q.fc[2:0], addr: q.src};
        end
      end
      drt_pkg::DRT_HOLD: begin
        if (pend_hold && !clear_now) begin
          s.fsm        = drt_pkg::DRT_RD;
          s.cidx       = 1'b0;
          s.last_op    = (q.bc == op_bytes);
          s.ext_hit    = 1'b0;
          s.steal_pend = 1'b0;
          s.await_ack  = !q.mode.mem2mem;
          s.cyc        = '{write: 1'b0, fc: q.fc[2:0], addr: q.src};
        end else begin
          s.fsm = drt_pkg::DRT_IDLE;
        end
      end
      drt_pkg::DRT_RD, drt_pkg::DRT_WR: begin
        if (cyc_err) begin
          // abort: any data read this operand is lost
          s.fsm                 = drt_pkg::DRT_IDLE;
          s.mode.channel_go_bit = 1'b0;
          s.stat.src_bus_fault_flag  = s.stat.src_bus_fault_flag || (q.fsm == drt_pkg::DRT_RD);
          s.stat.dest_bus_fault_flag = s.stat.dest_bus_fault_flag || (q.fsm == drt_pkg::DRT_WR);
          // an aborted operand would otherwise block steal requests for good
          s.await_ack           = 1'b0;
          s.irq_e               = q.mode.error_irq_enable;
        end else if (cyc_done) begin
          if (periph_side && final_cyc) begin
            s.burst_smp = q.periph_request_in_s;
          end
          if (periph_side && q.end_s) begin
            s.ext_hit = 1'b1;
          end
          if (!final_cyc) begin
            s.cidx     = 1'b1;
            s.cyc.addr = q.cyc.addr + `DRT_PTR_STEP;
          end else if (q.fsm == drt_pkg::DRT_RD) begin
            s.fsm  = drt_pkg::DRT_WR;
            s.cidx = 1'b0;
            s.cyc  = '{write: 1'b1, fc: q.fc[6:4], addr: q.dst};
          end else begin
            // operand complete: count moves in every case, each pointer only when its increment bit is set
            s.bc = bc_next;
            if (q.mode.src_inc) begin
              s.src = q.src + {8'h00, op_bytes};
            end
            if (q.mode.dst_inc) begin
              s.dst = q.dst + {8'h00, op_bytes};
            end
            if ((bc_next == `DRT_CNT_RST) || s.ext_hit) begin
              s.fsm                  = drt_pkg::DRT_IDLE;
              s.mode.channel_go_bit  = 1'b0;
              s.stat.complete_flag   = 1'b1;
              s.stat.external_end_flag = s.stat.external_end_flag || s.ext_hit;
              s.irq_n                = q.mode.normal_irq_enable;
            end else begin
              s.fsm = drt_pkg::DRT_HOLD;
            end
          end
        end
      end
      default: s.fsm = drt_pkg::DRT_IDLE;
    endcase
    // register read data, valid only in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `DRT_OFF_MODE:   s.rdata = {17'h00000, q.mode};
        `DRT_OFF_STATUS: s.rdata = {27'h0000000, owned, q.stat};
        `DRT_OFF_COUNT:  s.rdata = {16'h0000, q.bc};
        `DRT_OFF_SRC:    s.rdata = {8'h00, q.src};
        `DRT_OFF_DST:    s.rdata = {8'h00, q.dst};
        `DRT_OFF_FC:     s.rdata = {24'h000000, q.fc};
        default:         s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; reset loads constants only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '{fsm: drt_pkg::DRT_IDLE, mode: `DRT_MODE_RST, stat: `DRT_STAT_RST,
             bc: `DRT_CNT_RST, src: `DRT_PTR_RST, dst: `DRT_PTR_RST, fc: `DRT_FC_RST,
             cyc: '0, rdata: 32'h0000_0000, default: '0};
    end else begin
      q <= s;
    end
  end

  // outputs; block-end goes on the last cycle of the peripheral side, or of the side end_on_side_sel picks in memory to memory
  always_comb begin
    end_drive = owned && q.last_op && final_cyc &&
                (q.mode.mem2mem ? ((q.fsm == drt_pkg::DRT_WR) == q.mode.end_on_side_sel)
                                : periph_side);
  end
  assign reg_rdata      = q.rdata;
  assign bus_req        = (q.fsm != drt_pkg::DRT_IDLE);
  assign cyc_req        = owned;
  assign cyc_out        = q.cyc;
  assign periph_ack_out = owned && periph_side;
  assign blk_end_out    = end_drive;
  assign blk_end_oe     = end_drive;
  assign irq_normal     = q.irq_n;
  assign irq_error      = q.irq_e;

  // checks
  property p_go_gate;
    @(posedge clk) disable iff (!rst_b)
      (q.fsm == drt_pkg::DRT_IDLE && !q.mode.channel_go_bit) |=> (q.fsm == drt_pkg::DRT_IDLE);
  endproperty
  a_go_gate: assert property (p_go_gate) else $error("channel left idle with go clear");

  property p_max_rate;
    @(posedge clk) disable iff (!rst_b)
      (q.fsm == drt_pkg::DRT_HOLD && q.mode.channel_go_bit && !clear_now &&
       q.mode.request_source_sel == `DRT_REQ_MAX) |=> (q.fsm == drt_pkg::DRT_RD);
  endproperty
  a_max_rate: assert property (p_max_rate) else $error("maximum rate did not continue");

  property p_lim_stop;
    @(posedge clk) disable iff (!rst_b)
      (q.mode.request_source_sel == `DRT_REQ_LIM && q.used >= allot && q.win != `DRT_WIN_LAST &&
       (q.fsm == drt_pkg::DRT_IDLE || q.fsm == drt_pkg::DRT_HOLD)) |=> (q.fsm == drt_pkg::DRT_IDLE);
  endproperty
  a_lim_stop: assert property (p_lim_stop) else $error("share exceeded");

  property p_window;
    @(posedge clk) disable iff (!rst_b)
      (q.win == `DRT_WIN_LAST) |=> (q.used == 11'h000 && q.win == 10'h000);
  endproperty
  a_window: assert property (p_window) else $error("window did not restart");

  property p_ack;
    @(posedge clk) disable iff (!rst_b)
      periph_ack_out |-> (cyc_req && !q.mode.mem2mem && bus_req);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge outside peripheral cycle");

  property p_steal_ignore;
    @(posedge clk) disable iff (!rst_b)
      (q.await_ack && !q.steal_pend && !periph_ack_out) |=> !q.steal_pend;
  endproperty
  a_steal_ignore: assert property (p_steal_ignore) else $error("steal edge taken before acknowledge");

  property p_release;
    @(posedge clk) disable iff (!rst_b)
      (q.fsm == drt_pkg::DRT_HOLD && (!q.mode.channel_go_bit || clear_now)) |=> !cyc_req ##1 1'b1;
  endproperty
  a_release: assert property (p_release) else $error("bus kept after stop or clear");

  property p_count_end;
    @(posedge clk) disable iff (!rst_b)
      (q.fsm == drt_pkg::DRT_WR && cyc_done && !cyc_err && final_cyc && q.bc == op_bytes && !reg_wr)
      |=> (!q.mode.channel_go_bit && q.fsm == drt_pkg::DRT_IDLE && q.bc == `DRT_CNT_RST &&
           irq_normal == $past(q.mode.normal_irq_enable));
  endproperty
  a_count_end: assert property (p_count_end) else $error("count end not handled");

  property p_bus_err;
    @(posedge clk) disable iff (!rst_b)
      (owned && cyc_err && !reg_wr) |=> (!q.mode.channel_go_bit && !cyc_req &&
        irq_error == $past(q.mode.error_irq_enable) &&
        (q.stat.src_bus_fault_flag || q.stat.dest_bus_fault_flag));
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error not handled");

  property p_end_line;
    @(posedge clk) disable iff (!rst_b)
      blk_end_oe |-> (q.last_op && cyc_req && blk_end_out);
  endproperty
  a_end_line: assert property (p_end_line) else $error("block-end outside last operand");

  // main scenarios
  c_burst: cover property (@(posedge clk) disable iff (!rst_b)
    q.mode.request_source_sel == `DRT_REQ_BURST && q.fsm == drt_pkg::DRT_HOLD ##1 q.fsm == drt_pkg::DRT_RD);
  c_steal: cover property (@(posedge clk) disable iff (!rst_b)
    q.mode.request_source_sel == `DRT_REQ_STEAL && periph_ack_out && steal_edge);
  c_ext_end: cover property (@(posedge clk) disable iff (!rst_b) q.stat.external_end_flag && irq_normal);
  c_err: cover property (@(posedge clk) disable iff (!rst_b) irq_error);

endmodule

// ==== sim/drt_bus_model.sv ====
// Purpose: system bus responder that stands beyond the channel's bus port
// Assumes: grant follows the channel's bus request one clock late
// Notes:   lat stalls every cycle; err_arm turns each ending into a bus error
`timescale 1ns/1ps
module drt_bus_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // controls from the bench
  input  wire logic [3:0] lat,
  input  wire logic       err_arm,
  // bus side of the channel
  input  wire logic       bus_req,
  input  wire logic       cyc_req,
  output logic            bus_grant,
  output logic            cyc_done,
  output logic            cyc_err
);
  logic [3:0] wait_q;

  // one ending per cycle, then a quiet clock so the next cycle is seen fresh
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_grant <= 1'b0;
      cyc_done  <= 1'b0;
      cyc_err   <= 1'b0;
      wait_q    <= 4'h0;
    end else begin
      bus_grant <= bus_req;
      if (cyc_done || cyc_err || !cyc_req) begin
        cyc_done <= 1'b0;
        cyc_err  <= 1'b0;
        wait_q   <= 4'h0;
      end else if (wait_q == lat) begin
        cyc_done <= !err_arm;
        cyc_err  <= err_arm;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// ==== sim/drt_core_bench.sv ====
// Purpose: self-checking bench for the channel request and termination core
// Assumes: peripheral pins driven here, bus answered by drt_bus_model
// Notes:   bus clear inputs driven by one scenario; operand counts come from done pulses
`timescale 1ns/1ps
`include "drt_consts.svh"
module drt_core_bench;
  logic clk, rst_b, reg_wr, reg_rd, bus_req, bus_grant, cyc_req, cyc_done, cyc_err;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic periph_request_in, periph_ack_out, blk_end_in, blk_end_out, blk_end_oe;
  logic irq_normal, irq_error, err_arm;
  logic ext_master_req, core_irq_pend, tally_clr;
  logic [3:0] lat;
  drt_pkg::drt_cyc_t cyc_out;
  int err_total, comparisons, n_ack, n_end, n_ops, n_irqn, n_irqe, n_endw, n_own;

  drt_core DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req),
    .bus_grant(bus_grant), .ext_master_req(ext_master_req), .core_irq_pend(core_irq_pend), .cyc_req(cyc_req),
    .cyc_out(cyc_out), .cyc_done(cyc_done), .cyc_err(cyc_err),
    .periph_request_in(periph_request_in), .periph_ack_out(periph_ack_out),
    .blk_end_in(blk_end_in), .blk_end_out(blk_end_out), .blk_end_oe(blk_end_oe),
    .irq_normal(irq_normal), .irq_error(irq_error));
  drt_bus_model BUS (.clk(clk), .rst_b(rst_b), .lat(lat), .err_arm(err_arm), .bus_req(bus_req),
    .cyc_req(cyc_req), .bus_grant(bus_grant), .cyc_done(cyc_done), .cyc_err(cyc_err));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // tallies of completed cycles, owned clocks and interrupt pulses
  // cleared only here, so a clear and a count never race at one edge
  always @(posedge clk) begin
    if (tally_clr) begin
      {n_ack, n_end, n_endw, n_own, n_ops, n_irqn, n_irqe} <= '0;
    end else begin
      n_ack  <= n_ack + (periph_ack_out && cyc_done);
      n_end  <= n_end + (blk_end_out && cyc_done);
      n_endw <= n_endw + (blk_end_out && cyc_done && cyc_out.write);
      n_own  <= n_own + cyc_req;
      n_ops  <= n_ops + (cyc_out.write && cyc_done);
      n_irqn <= n_irqn + irq_normal;
      n_irqe <= n_irqe + irq_error;
    end
  end

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register port: one-cycle strobes, read data only in the next cycle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task clr;
    tally_clr <= 1'b1;
    @(posedge clk);
    tally_clr <= 1'b0;
  endtask

  // bounded wait for the channel to let go of the bus
  task wait_idle;
    int i;
    repeat (4) @(posedge clk);
    for (i = 0; i < 3000 && bus_req !== 1'b0; i++) @(posedge clk);
    if (i == 3000) chk(bus_req, 32'h0);
    // let the tallies take the last done and the interrupt pulse
    repeat (2) @(posedge clk);
  endtask

  task t_reset;
    rd(`DRT_OFF_MODE, 32'h0);
    rd(`DRT_OFF_STATUS, 32'h0);
    rd(`DRT_OFF_COUNT, 32'h0);
    rd(8'hFC, 32'h0);
  endtask

  task t_max;
    lat <= 4'h0;
    wr(`DRT_OFF_COUNT, 32'h1);
    clr;
    wr(`DRT_OFF_MODE, 32'h81);
    wait_idle;
    chk(n_ack, 32'h1);
    chk(n_end, 32'h1);
    chk(n_endw, 32'h0);
    chk(n_ops, 32'h1);
    chk(n_irqn, 32'h1);
    rd(`DRT_OFF_STATUS, 32'h1);
    rd(`DRT_OFF_MODE, 32'h80);
    wr(`DRT_OFF_STATUS, 32'hF);
    lat <= 4'h2;
  endtask

  // memory to memory, block end on the destination write
  task t_m2m;
    wr(`DRT_OFF_COUNT, 32'h1);
    clr;
    wr(`DRT_OFF_MODE, 32'h441);
    wait_idle;
    chk(n_ack, 32'h0);
    chk(n_end, 32'h1);
    chk(n_endw, 32'h1);
    rd(`DRT_OFF_STATUS, 32'h1);
    wr(`DRT_OFF_STATUS, 32'hF);
  endtask

  task t_limit;
    wr(`DRT_OFF_COUNT, 32'h2);
    clr;
    wr(`DRT_OFF_MODE, 32'h0B);
    wait_idle;
    chk(n_ops, 32'h2);
    chk(n_irqn, 32'h0);
    rd(`DRT_OFF_STATUS, 32'h1);
    wr(`DRT_OFF_STATUS, 32'hF);
  endtask

  // one eighth of each 1024-clock window: 128 owned clocks, one operand of overshoot
  task t_share;
    lat <= 4'h0;
    wr(`DRT_OFF_COUNT, 32'h100);
    clr;
    wr(`DRT_OFF_MODE, 32'h03);
    repeat (2048) @(posedge clk);
    chk(n_own >= 128 && n_own <= 396, 32'h1);
    chk(n_ops > 0 && n_ops < 256, 32'h1);
    wr(`DRT_OFF_MODE, 32'h02);
    wait_idle;
    chk(bus_req, 32'h0);
    rd(`DRT_OFF_MODE, 32'h02);
    lat <= 4'h2;
  endtask

  // bus clear ends after the operand, resumes where it stopped
  task t_clear;
    int i;
    wr(`DRT_OFF_COUNT, 32'h20);
    clr;
    wr(`DRT_OFF_MODE, 32'h01);
    for (i = 0; i < 500 && n_ops < 2; i++) @(posedge clk);
    ext_master_req <= 1'b1;
    wait_idle;
    chk(n_ops < 32, 32'h1);
    rd(`DRT_OFF_COUNT, 32'h20 - n_ops);
    rd(`DRT_OFF_MODE, 32'h01);
    // a core interrupt with the mask clear must not stop the channel
    ext_master_req <= 1'b0;
    core_irq_pend  <= 1'b1;
    wait_idle;
    core_irq_pend  <= 1'b0;
    chk(n_ops, 32'h20);
    wr(`DRT_OFF_STATUS, 32'hF);
  endtask

  task t_burst;
    int i;
    wr(`DRT_OFF_MODE, 32'h04);
    periph_request_in <= 1'b1;
    repeat (20) @(posedge clk);
    chk(bus_req, 32'h0);
    wr(`DRT_OFF_COUNT, 32'h3);
    clr;
    wr(`DRT_OFF_MODE, 32'h05);
    wr(`DRT_OFF_COUNT, 32'h10);
    wait_idle;
    chk(n_ops, 32'h3);
    rd(`DRT_OFF_COUNT, 32'h0);
    wr(`DRT_OFF_COUNT, 32'h8);
    clr;
    wr(`DRT_OFF_MODE, 32'h05);
    for (i = 0; i < 500 && n_ops < 1; i++) @(posedge clk);
    periph_request_in <= 1'b0;
    wait_idle;
    repeat (20) @(posedge clk);
    chk(bus_req, 32'h0);
    chk(n_ops < 8, 32'h1);
    wr(`DRT_OFF_MODE, 32'h04);
    rd(`DRT_OFF_MODE, 32'h04);
    wr(`DRT_OFF_MODE, 32'h05);
    periph_request_in <= 1'b1;
    wait_idle;
    periph_request_in <= 1'b0;
    chk(n_ops, 32'h8);
    rd(`DRT_OFF_MODE, 32'h04);
    wr(`DRT_OFF_STATUS, 32'hF);
  endtask

  task t_steal;
    int i;
    wr(`DRT_OFF_COUNT, 32'h0);
    clr;
    wr(`DRT_OFF_MODE, 32'h07);
    // two edges before any acknowledge count as one request
    periph_request_in <= 1'b1;
    @(posedge clk);
    periph_request_in <= 1'b0;
    @(posedge clk);
    periph_request_in <= 1'b1;
    @(posedge clk);
    periph_request_in <= 1'b0;
    // one edge after the acknowledge is served before the bus goes
    for (i = 0; i < 100 && periph_ack_out !== 1'b1; i++) @(posedge clk);
    periph_request_in <= 1'b1;
    @(posedge clk);
    periph_request_in <= 1'b0;
    wait_idle;
    repeat (20) @(posedge clk);
    chk(n_ops, 32'h2);
    chk(n_ack, 32'h2);
    rd(`DRT_OFF_COUNT, 32'hFFFE);
    wr(`DRT_OFF_MODE, 32'h06);
  endtask

  task t_ext_end;
    blk_end_in <= 1'b1;
    wr(`DRT_OFF_COUNT, 32'h10);
    clr;
    wr(`DRT_OFF_MODE, 32'h81);
    wait_idle;
    blk_end_in <= 1'b0;
    chk(n_ops, 32'h1);
    chk(n_irqn, 32'h1);
    rd(`DRT_OFF_STATUS, 32'h3);
    rd(`DRT_OFF_COUNT, 32'hF);
    rd(`DRT_OFF_MODE, 32'h80);
    wr(`DRT_OFF_STATUS, 32'hF);
  endtask

  task t_err;
    err_arm <= 1'b1;
    wr(`DRT_OFF_COUNT, 32'h4);
    clr;
    wr(`DRT_OFF_MODE, 32'h101);
    wait_idle;
    err_arm <= 1'b0;
    chk(n_irqe, 32'h1);
    chk(n_ops, 32'h0);
    rd(`DRT_OFF_STATUS, 32'h8);
    rd(`DRT_OFF_MODE, 32'h100);
    wr(`DRT_OFF_STATUS, 32'hF);
    rd(`DRT_OFF_STATUS, 32'h0);
  endtask

  // main sequence after a 12-cycle reset
  initial begin
    {rst_b, reg_wr, reg_rd, periph_request_in, blk_end_in, err_arm} = '0;
    {ext_master_req, core_irq_pend} = '0;
    tally_clr = 1'b1;
    {reg_addr, reg_wdata} = '0;
    lat = 4'h2;
    {err_total, comparisons} = '0;
    repeat (12) @(posedge clk);
    rst_b     <= 1'b1;
    tally_clr <= 1'b0;
    t_reset;
    t_max;
    t_m2m;
    t_limit;
    t_share;
    t_clear;
    t_burst;
    t_steal;
    t_ext_end;
    t_err;
    summarize;
  end

  // hang guard, far beyond the few thousand clocks the tests need
  initial begin
    #200000;
    err_total++;
    summarize;
  end
endmodule
